// ---- hdl/misc_ctrl_defs.vh ----
/*
  Constants for the per-channel misc control block: word addresses,
  field positions, reset values, command codes and timing counts.
  Assumes inclusion by bare name from the design modules.
*/
`ifndef MISC_CTRL_DEFS_VH
`define MISC_CTRL_DEFS_VH

// Avalon word addresses (byte address is four times these)
`define ADDR_MISC_CTRL    3'h0
`define ADDR_IRQ_EN       3'h1
`define ADDR_AUX_CTRL     3'h2
`define ADDR_BAUD_TC      3'h3
`define ADDR_MISC_STATUS  3'h4

// Clock recovery loop commands, bits 7:5 of misc_control_reg
`define CMD_NULL          3'h0
`define CMD_SEARCH        3'h1
`define CMD_RESET_MISSING 3'h2
`define CMD_DISABLE       3'h3
`define CMD_SRC_BAUD      3'h4
`define CMD_SRC_PIN       3'h5
`define CMD_FM            3'h6
`define CMD_NRZI          3'h7

// misc_control_reg field positions
`define MC_CMD_HI         7
`define MC_CMD_LO         5
`define MC_LOOPBACK       4
`define MC_ECHO           3
`define MC_REQ_FN         2
`define MC_BAUD_SRC       1
`define MC_BAUD_EN        0

// ext_status_irq_enable_reg field positions and reset value
`define IE_BREAK          7
`define IE_UNDERRUN       6
`define IE_CTS            5
`define IE_SYNC_HUNT      4
`define IE_DCD            3
`define IE_STAT_FIFO      2
`define IE_ZERO_COUNT     1
`define IE_PRIME          0
`define IE_RESET          8'hF8

// aux control field positions
`define AUX_DTR           0
`define AUX_CRYSTAL_OSCILLATOR_SEL      1
`define AUX_REQ_FAST      2
`define AUX_SYNC_MODE     3
`define AUX_SDLC_MODE     4

// Recovery loop timing in sample ticks; baud generator start delay in baud counts
`define NRZI_FIRST_SAMPLE 16
`define FM_TICKS_PER_BIT  16
`define BAUD_START_COUNTS 2

// Request deassert delay in core clocks, three to four after the strobe
`define REQ_DEASSERT_CLKS 3

`endif

// ---- hdl/pin_sync.v ----
/*
  Two flip-flop synchroniser for a bundle of independent level inputs.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             rstn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;  // First stage, read only by second stage

  // Plain two-stage capture, synchronous reset
  always @(posedge core_clk) begin
    if (!rstn) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // pin_sync

// ---- hdl/clock_recovery_loop.v ----
/*
  Clock recovery loop: searches for a locking edge, then tracks the data
  with a sample counter advanced once per recovery tick.
  Assumes tick is a one-cycle pulse and data is already synchronised.
*/
`timescale 1ns/100ps
`include "misc_ctrl_defs.vh"
module clock_recovery_loop (
  input  wire core_clk,
  input  wire rstn,
  input  wire tick,         // One pulse per recovery clock
  input  wire data,         // Synchronised serial data
  input  wire enable,       // Loop enabled
  input  wire fm_mode,      // 1 FM, 0 NRZI
  input  wire clear_missing,// Clear both missing latches
  output reg  searching,    // Waiting for first edge
  output reg  one_missing,  // Sticky one-clock-missing
  output reg  two_missing,  // Sticky two-clocks-missing
  output reg  recovered     // Recovered clock level
);

  reg [4:0] phase;          // Ticks since last bit start
  reg       data_q;         // Previous data for edge detect
  reg       odd_bit;        // FM checks every other bit only
  reg       seen;           // Edge seen in the current window
  reg       miss_run;       // One miss already outstanding

  wire edge_now = tick & (data ^ data_q);
  wire [4:0] wrap = fm_mode ? 5'h0F : 5'h1F;
  // FM window straddles the bit boundary
  wire in_win = (phase >= 5'h0E) | (phase <= 5'h01);

  // Tracking, search and missing-clock detection
  always @(posedge core_clk) begin
    if (!rstn) begin
      phase       <= 5'h00;
      data_q      <= 1'b1;   // Line idles marking; no false first edge
      odd_bit     <= 1'b0;
      seen        <= 1'b0;
      miss_run    <= 1'b0;
      searching   <= 1'b1;
      one_missing <= 1'b0;
      two_missing <= 1'b0;
      recovered   <= 1'b1;
    end else begin
      if (tick)
        data_q <= data;
      if (!enable || searching) begin
        // Idle level depends on mode while waiting for an edge
        recovered <= ~fm_mode;
        phase     <= 5'h00;
        odd_bit   <= 1'b0;
        seen      <= edge_now;   // Locking edge fills the first window
        miss_run  <= 1'b0;
        if (!enable)
          searching <= 1'b1;
        else if (edge_now)
          searching <= 1'b0;
      end else if (tick) begin
        phase <= (phase == wrap) ? 5'h00 : phase + 5'h01;
        // NRZI: rise 16 ticks into the bit, then every 32 ticks
        if (!fm_mode)
          recovered <= (phase + 5'h01 >= `NRZI_FIRST_SAMPLE) &&
                       (phase != wrap);
        else
          recovered <= phase[2] ^ (phase == 5'h03) ^ (phase == 5'h0B);
        if (phase == wrap)
          odd_bit <= ~odd_bit;
        if (edge_now && !fm_mode) begin
          // Nudge the phase toward the edge
          if (phase != 5'h00 && phase < 5'h10)
            phase <= phase;
          else if (phase >= 5'h10 && phase != wrap)
            phase <= phase + 5'h02;
        end
        if (fm_mode && !odd_bit && in_win && edge_now)
          seen <= 1'b1;
        // Window closes two ticks after the boundary
        if (fm_mode && !odd_bit && phase == 5'h02) begin
          seen <= 1'b0;
          if (seen || edge_now) begin
            miss_run <= 1'b0;
          end else if (miss_run) begin
            two_missing <= 1'b1;
            searching   <= 1'b1;
          end else begin
            one_missing <= 1'b1;
            miss_run    <= 1'b1;
          end
        end
      end
      if (clear_missing) begin
        one_missing <= 1'b0;
        two_missing <= 1'b0;
      end
    end
  end

endmodule // clock_recovery_loop

// ---- hdl/clock_recovery_loop_brg_misc_control.v ----
/*
  Per-channel misc control: clock recovery command decode, loopback and
  echo paths, terminal-ready/request pin, baud generator, and the
  external/status change detector with per-source enables.
  Assumes an Avalon-MM master on core_clk; all pins are asynchronous and
  are synchronised here; transmitter-side inputs are on core_clk.
*/
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "misc_ctrl_defs.vh"
module clock_recovery_loop_brg_misc_control #(
  parameter TC_WIDTH = 16     // Baud time constant width
) (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        chan_reset,        // Channel reset pulse
  // Avalon-MM slave
  input  wire [2:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Pins from the far side
  input  wire        shared_clock_pin,
  input  wire        crystal_oscillator,
  input  wire        rxd_pin,
  input  wire        cts_pin,
  input  wire        carrier_detect_pin,
  input  wire        sync_pin,
  // Transmitter and receiver side, core_clk domain
  input  wire        tx_data,
  input  wire        tx_buffer_empty,
  input  wire        crc_sent,
  input  wire        break_status,
  input  wire        underrun_latch,
  input  wire        hunt_status,
  output reg         txd_pin,
  output reg         rx_data,
  output reg         cts_enable,
  output reg         dcd_enable,
  output reg         terminal_ready_req_n,
  output reg         baud_out,
  output reg         recovered_clock,
  output reg         ext_status_event,
  output reg         status_fifo_active,
  output reg         prime_select
);

  // Two-flop synchronised pins
  wire [5:0] pins_s;
  wire       sclk_s = pins_s[0];
  wire       crystal_oscillator_s = pins_s[1];
  wire       rxd_s  = pins_s[2];
  wire       cts_s  = pins_s[3];
  wire       dcd_s  = pins_s[4];
  wire       sync_s = pins_s[5];

  pin_sync #(.WIDTH(6)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({sync_pin, carrier_detect_pin, cts_pin, rxd_pin,
                crystal_oscillator, shared_clock_pin}),
    .sync_out (pins_s)
  );

  // Control state
  reg  [4:0]          misc_ctrl;     // Stored bits 4:0 of misc_control_reg
  reg  [7:0]          irq_en;        // ext_status_irq_enable_reg
  reg  [4:0]          aux_ctrl;      // DTR, crystal select, mode bits
  reg  [TC_WIDTH-1:0] baud_tc;       // Baud time constant
  reg                 loop_enable;   // Recovery loop enabled
  reg                 loop_fm;       // 1 FM, 0 NRZI
  reg                 loop_src_baud; // 1 baud generator, 0 pin/crystal
  reg                 clr_missing;   // Pulse into recovery loop
  reg                 src_q;         // Previous pin/crystal level
  reg                 baud_q;        // Previous baud output
  reg  [TC_WIDTH-1:0] baud_cnt;      // Down counter
  reg  [1:0]          start_cnt;     // Counts left before output moves
  reg                 reload;        // Reload count after zero
  reg  [5:0]          prev_src;      // Previous interrupt sources
  reg                 req_active;    // Request condition, delayed
  reg  [2:0]          req_dly;       // Deassert delay line

  wire acc_ok  = waitrequest == 1'b0;
  wire wr_ok   = write & acc_ok;
  wire [2:0] cmd = writedata[`MC_CMD_HI:`MC_CMD_LO];
  wire cmd_wr  = wr_ok && address == `ADDR_MISC_CTRL;
  wire any_rst = chan_reset;

  // Pin or crystal chosen by the crystal-select bit
  wire pin_src   = aux_ctrl[`AUX_CRYSTAL_OSCILLATOR_SEL] ? crystal_oscillator_s : sclk_s;
  wire pin_tick  = pin_src & ~src_q;
  // Baud counter clocked every core clock or on pin edges
  wire baud_tick = misc_ctrl[`MC_BAUD_SRC] ? 1'b1 : pin_tick;
  wire baud_rise = baud_out & ~baud_q;
  wire clock_recovery_loop_tick = loop_src_baud ? baud_rise : pin_tick;
  wire zero_cnt  = misc_ctrl[`MC_BAUD_EN] && baud_cnt == {TC_WIDTH{1'b0}};

  // Status bits held by the recovery loop
  wire loop_search;
  wire loop_one_miss;
  wire loop_two_miss;
  wire loop_clk;

  clock_recovery_loop u_loop (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .tick          (clock_recovery_loop_tick),
    .data          (rx_data),
    .enable        (loop_enable),
    .fm_mode       (loop_fm),
    .clear_missing (clr_missing),
    .searching     (loop_search),
    .one_missing   (loop_one_miss),
    .two_missing   (loop_two_miss),
    .recovered     (loop_clk)
  );

  // Register readback mux, write-only registers read as zero
  function [31:0] read_mux;
    input [2:0] addr;
    begin
      case (addr)
        `ADDR_AUX_CTRL:    read_mux = {27'h0000000, aux_ctrl};
        `ADDR_BAUD_TC:     read_mux = {{(32-TC_WIDTH){1'b0}}, baud_tc};
        `ADDR_MISC_STATUS: read_mux = {24'h000000, terminal_ready_req_n,
                                       baud_out, loop_src_baud, loop_fm,
                                       loop_enable, loop_search,
                                       loop_two_miss, loop_one_miss};
        default:           read_mux = 32'h00000000;
      endcase
    end
  endfunction

  // Bus handshake: one wait cycle, then the access completes
  always @(posedge core_clk) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else if ((read | write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= read_mux(address);
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Register writes and command decode
  always @(posedge core_clk) begin
    if (!rstn) begin
      misc_ctrl     <= 5'h00;
      irq_en        <= `IE_RESET;
      aux_ctrl      <= 5'h00;
      baud_tc       <= {TC_WIDTH{1'b0}};
      loop_enable   <= 1'b0;
      loop_fm       <= 1'b0;
      loop_src_baud <= 1'b0;
      clr_missing   <= 1'b1;
    end else begin
      clr_missing <= 1'b0;
      if (any_rst) begin
        // Channel reset keeps the baud source and enable
        misc_ctrl[4:2] <= 3'h0;
        irq_en         <= `IE_RESET;
        loop_enable    <= 1'b0;
        loop_fm        <= 1'b0;
        loop_src_baud  <= 1'b0;
        clr_missing    <= 1'b1;
      end else if (wr_ok) begin
        case (address)
          `ADDR_MISC_CTRL: begin
            misc_ctrl <= writedata[4:0];
          end
          `ADDR_IRQ_EN: begin
            irq_en <= writedata[7:0];
          end
          `ADDR_AUX_CTRL: begin
            aux_ctrl <= writedata[4:0];
          end
          `ADDR_BAUD_TC: begin
            baud_tc <= writedata[TC_WIDTH-1:0];
          end
          default: begin
            // Unmapped writes ignored
          end
        endcase
      end
      if (cmd_wr && !any_rst) begin
        case (cmd)
          `CMD_SEARCH: begin
            loop_enable <= 1'b1;
            clr_missing <= 1'b1;
          end
          `CMD_RESET_MISSING, `CMD_DISABLE: begin
            loop_enable <= 1'b0;
            clr_missing <= 1'b1;
          end
          `CMD_SRC_BAUD: loop_src_baud <= 1'b1;
          `CMD_SRC_PIN:  loop_src_baud <= 1'b0;
          `CMD_FM:       loop_fm       <= 1'b1;
          `CMD_NRZI:     loop_fm       <= 1'b0;
          default: begin
            // Null command
          end
        endcase
      end
    end
  end

  // Baud generator: reload at zero, output toggles each reload
  always @(posedge core_clk) begin
    if (!rstn) begin
      src_q     <= 1'b0;
      baud_q    <= 1'b0;
      baud_cnt  <= {TC_WIDTH{1'b0}};
      start_cnt <= `BAUD_START_COUNTS;
      baud_out  <= 1'b0;
      reload    <= 1'b0;
    end else begin
      src_q  <= pin_src;
      baud_q <= baud_out;
      if (!misc_ctrl[`MC_BAUD_EN]) begin
        // Stop at once; rearm the start delay
        baud_cnt  <= baud_tc;
        start_cnt <= `BAUD_START_COUNTS;
        reload    <= 1'b0;
      end else if (baud_tick) begin
        // Reload takes a count of its own: half period is N+2 counts
        if (reload) begin
          baud_cnt <= baud_tc;
          reload   <= 1'b0;
        end else if (baud_cnt == {TC_WIDTH{1'b0}}) begin
          reload <= 1'b1;
          if (start_cnt == 2'h0)
            baud_out <= ~baud_out;
        end else begin
          baud_cnt <= baud_cnt - {{(TC_WIDTH-1){1'b0}}, 1'b1};
        end
        // Output held off for the first two counts
        if (start_cnt != 2'h0)
          start_cnt <= start_cnt - 2'h1;
      end
    end
  end

  // Data paths and pin enables
  always @(posedge core_clk) begin
    if (!rstn) begin
      txd_pin            <= 1'b1;
      rx_data            <= 1'b1;
      cts_enable         <= 1'b0;
      dcd_enable         <= 1'b0;
      recovered_clock    <= 1'b1;
      status_fifo_active <= 1'b0;
      prime_select       <= 1'b0;
    end else begin
      // Echo wins the line; transmit data is never seen then
      if (misc_ctrl[`MC_ECHO])
        txd_pin <= rxd_s;
      else
        txd_pin <= tx_data;
      rx_data <= (misc_ctrl[`MC_LOOPBACK] && !misc_ctrl[`MC_ECHO]) ?
                 tx_data : rxd_s;
      // Loopback forces both enables on, echo forces only CTS; interrupts still see pins
      cts_enable <= misc_ctrl[`MC_LOOPBACK] | misc_ctrl[`MC_ECHO] |
                    ~cts_s;
      dcd_enable <= misc_ctrl[`MC_LOOPBACK] | ~dcd_s;
      recovered_clock    <= loop_clk;
      status_fifo_active <= irq_en[`IE_STAT_FIFO] &
                            aux_ctrl[`AUX_SDLC_MODE];
      prime_select       <= irq_en[`IE_PRIME];
    end
  end

  // Terminal-ready or request pin
  always @(posedge core_clk) begin
    if (!rstn) begin
      req_dly              <= 3'h0;
      req_active           <= 1'b0;
      terminal_ready_req_n <= 1'b1;
    end else begin
      req_dly <= {req_dly[1:0], tx_buffer_empty |
                 (aux_ctrl[`AUX_SYNC_MODE] & crc_sent)};
      // Assert at once; deassert late unless the fast option is set
      if (req_dly[0])
        req_active <= 1'b1;
      else if (aux_ctrl[`AUX_REQ_FAST] || req_dly[`REQ_DEASSERT_CLKS-1:0] == 3'h0)
        req_active <= 1'b0;
      if (misc_ctrl[`MC_REQ_FN])
        terminal_ready_req_n <= ~req_active;
      else
        terminal_ready_req_n <= ~aux_ctrl[`AUX_DTR];
    end
  end

  // External/status change detector; only fresh changes count
  always @(posedge core_clk) begin
    if (!rstn) begin
      prev_src         <= 6'h00;
      ext_status_event <= 1'b0;
    end else begin
      prev_src <= {break_status, underrun_latch, cts_s,
                   aux_ctrl[`AUX_SYNC_MODE] ? hunt_status : sync_s,
                   dcd_s, zero_cnt};
      ext_status_event <=
        (irq_en[`IE_BREAK]     & (break_status ^ prev_src[5])) |
        (irq_en[`IE_UNDERRUN]  & underrun_latch & ~prev_src[4]) |
        (irq_en[`IE_CTS]       & (cts_s ^ prev_src[3])) |
        (irq_en[`IE_SYNC_HUNT] & ((aux_ctrl[`AUX_SYNC_MODE] ?
                                   hunt_status : sync_s) ^ prev_src[2])) |
        (irq_en[`IE_DCD]       & (dcd_s ^ prev_src[1])) |
        (irq_en[`IE_ZERO_COUNT] & zero_cnt & ~prev_src[0]);
    end
  end

endmodule // clock_recovery_loop_brg_misc_control

// ---- testbench/misc_ctrl_asserts.sv ----
/*
  Checker for the misc control block: handshake, data paths, request pin,
  event pulse and flag outputs, judged against shadow registers.
  Assumes binding to the top module; single core_clk domain.
*/
`timescale 1ns/100ps
`include "misc_ctrl_defs.vh"
module misc_ctrl_asserts (
  input logic        core_clk,
  input logic        rstn,
  input logic        chan_reset,
  input logic [2:0]  address,
  input logic        read,
  input logic        write,
  input logic [31:0] writedata,
  input logic        waitrequest,
  input logic        tx_data,
  input logic        tx_buffer_empty,
  input logic        rxd_pin,
  input logic        break_status,
  input logic        txd_pin,
  input logic        rx_data,
  input logic        cts_enable,
  input logic        dcd_enable,
  input logic        terminal_ready_req_n,
  input logic        ext_status_event,
  input logic        status_fifo_active,
  input logic        prime_select
);
  logic [7:0] mc;   // Shadow of misc_control_reg
  logic [7:0] ie;   // Shadow of ext_status_irq_enable_reg
  logic [7:0] aux;  // Shadow of aux control
  wire        fifo_want = ie[`IE_STAT_FIFO] & aux[`AUX_SDLC_MODE]; // Queue should run

  // Shadows follow completed writes; channel reset keeps baud bits
  always @(posedge core_clk) begin
    if (!rstn) begin
      mc  <= 8'h00;
      ie  <= `IE_RESET;
      aux <= 8'h00;
    end else if (chan_reset) begin
      mc[4:2] <= 3'h0;
      ie      <= `IE_RESET;
    end else if (write && !waitrequest) begin
      if (address == `ADDR_MISC_CTRL) mc <= writedata[7:0];
      if (address == `ADDR_IRQ_EN) ie <= writedata[7:0];
      if (address == `ADDR_AUX_CTRL) aux <= writedata[7:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Pin held low four cycles after the buffer refills
  sequence held_low;
    !terminal_ready_req_n [*4];
  endsequence

  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  loop_path_a: assert property ((mc[4] && !mc[3]) [*2] |->
    rx_data == $past(tx_data) && txd_pin == $past(tx_data))
    else $error("loopback data path wrong");
  loop_enables_a: assert property (mc[4] [*3] |-> cts_enable && dcd_enable)
    else $error("enables not forced in loopback");
  echo_path_a: assert property ((mc[3] && $stable(rxd_pin)) [*6] |-> txd_pin == rxd_pin)
    else $error("echo output does not follow input");
  dtr_follow_a: assert property ((!mc[2] && $stable(aux[0])) [*4] |->
    terminal_ready_req_n == !aux[0])
    else $error("pin does not follow terminal ready bit");
  req_low_a: assert property ((mc[2] && tx_buffer_empty) [*6] |-> !terminal_ready_req_n)
    else $error("request not asserted on empty buffer");
  req_late_a: assert property (mc[2] && !aux[2] && !terminal_ready_req_n &&
    $fell(tx_buffer_empty) |-> held_low ##[1:2] terminal_ready_req_n)
    else $error("request release timing wrong");
  break_irq_a: assert property (ie[7] && $changed(break_status) |-> ##[1:2] ext_status_event)
    else $error("enabled break change gave no event");
  quiet_irq_a: assert property ((ie == 8'h00) [*3] |-> !ext_status_event)
    else $error("event with all sources disabled");
  fifo_flag_a: assert property ($stable(fifo_want) [*2] |-> status_fifo_active == fifo_want)
    else $error("status queue flag wrong");
  prime_flag_a: assert property ($stable(ie[0]) [*2] |-> prime_select == ie[0])
    else $error("alternate register select wrong");
endmodule // misc_ctrl_asserts

bind clock_recovery_loop_brg_misc_control misc_ctrl_asserts u_checker (.core_clk, .rstn, .chan_reset,
  .address, .read, .write, .writedata, .waitrequest, .tx_data, .tx_buffer_empty, .rxd_pin,
  .break_status, .txd_pin, .rx_data, .cts_enable, .dcd_enable, .terminal_ready_req_n,
  .ext_status_event, .status_fifo_active, .prime_select);

// ---- testbench/far_side_model.sv ----
/*
  Far side of the channel: link clock on the shared pin, serial line with
  one edge per 16 link clocks, crystal and modem pins.
  Assumes the bench drives run, data_on and lines.
*/
`timescale 1ns/100ps
module far_side_model (
  input  logic       run,                // Link clock runs
  input  logic       data_on,            // Line carries edges
  input  logic [2:0] lines,              // Clear-to-send, carrier, sync levels
  output logic       shared_clock_pin,
  output logic       crystal_oscillator,
  output logic       rxd_pin,
  output logic       cts_pin,
  output logic       carrier_detect_pin,
  output logic       sync_pin
);
  int k;  // Link clock count

  // Modem pins are plain levels from the bench
  assign {cts_pin, carrier_detect_pin, sync_pin} = lines;

  // Crystal runs free, unrelated in phase to everything else
  initial begin
    crystal_oscillator = 1'b0;
    forever #27 crystal_oscillator = ~crystal_oscillator;
  end

  // Link clock of 80 ns only while running; line idles marking
  initial begin
    shared_clock_pin = 1'b0;
    rxd_pin          = 1'b1;
    k                = 0;
    forever begin
      wait (run);
      #40 shared_clock_pin = 1'b1;
      #40 shared_clock_pin = 1'b0;
      k++;
      if (data_on && k % 16 == 0) rxd_pin = ~rxd_pin;
    end
  end
endmodule // far_side_model

// ---- testbench/clock_recovery_loop_brg_misc_control_tb.sv ----
/*
  Bench for the misc control block: register bus tasks, command walk,
  missing clocks, baud generator, events, request pin, data paths.
  Assumes far_side_model on the pins and the bound checker.
*/
`timescale 1ns/100ps
`include "misc_ctrl_defs.vh"
module clock_recovery_loop_brg_misc_control_tb;
  logic        core_clk, rstn, chan_reset, read, write;  // Bus and reset
  logic [2:0]  address;
  logic [31:0] writedata, v;
  logic        tx_data, tx_buffer_empty, crc_sent;       // Transmitter side
  logic        break_status, underrun_latch, hunt_status;
  logic        run, data_on, last_baud;
  logic [2:0]  lines;
  wire  [31:0] readdata;
  wire         waitrequest, shared_clock_pin, crystal_oscillator, rxd_pin, cts_pin;
  wire         carrier_detect_pin, sync_pin, txd_pin, rx_data, cts_enable, dcd_enable;
  wire         terminal_ready_req_n, baud_out, recovered_clock, ext_status_event;
  wire         status_fifo_active, prime_select;
  int          failures, samples_checked, cycles, toggles, events, t0, e0;
  // Command walk and status bits 5:0 expected after each
  logic [2:0]  cmds [9] = '{3'h1, 3'h6, 3'h1, 3'h4, 3'h5, 3'h7, 3'h3, 3'h2, 3'h0};
  logic [7:0]  exps [9] = '{8'h0C, 8'h1C, 8'h1C, 8'h3C, 8'h1C, 8'h0C, 8'h04, 8'h04, 8'h04};

  far_side_model far (.run(run), .data_on(data_on), .lines(lines),
    .shared_clock_pin(shared_clock_pin), .crystal_oscillator(crystal_oscillator),
    .rxd_pin(rxd_pin), .cts_pin(cts_pin), .carrier_detect_pin(carrier_detect_pin),
    .sync_pin(sync_pin));

  clock_recovery_loop_brg_misc_control dut (.*);

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Edge and event counters; the ceiling cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (baud_out !== last_baud) toggles++;
    last_baud = baud_out;
    if (ext_status_event === 1'b1) events++;
    if (cycles == 20000) begin
      failures++;
      end_of_test;
    end
  end

  task end_of_test;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus cycles: hold until waitrequest is seen low at an edge
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= 1'b1;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  task rd(input logic [2:0] a, output logic [31:0] q);
    @(posedge core_clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
  endtask

  task st(input logic [7:0] m, input logic [7:0] e);
    rd(`ADDR_MISC_STATUS, v);
    chk(v & {24'h0, m}, {24'h0, e});
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Main sequence
  initial begin
    {rstn, chan_reset, read, write, address, writedata} = '0;
    {tx_data, tx_buffer_empty, crc_sent, break_status, underrun_latch, hunt_status} = '0;
    {run, data_on, last_baud} = '0;
    lines = 3'h7;
    {failures, samples_checked, cycles, toggles, events} = '0;
    tick(2);
    rstn <= 1'b1;
    tick(1);
    st(8'h3B, 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(`ADDR_MISC_CTRL, {cmds[i], 5'h00});
      st(8'h3F, exps[i]);
      if (cmds[i] == `CMD_SEARCH) chk(32'(recovered_clock), 32'(!exps[i][4]));
    end
    wr(`ADDR_MISC_CTRL, {`CMD_FM, 5'h00});
    wr(`ADDR_MISC_CTRL, {`CMD_SEARCH, 5'h00});
    run <= 1'b1;
    data_on <= 1'b1;
    tick(600);
    st(8'h07, 8'h00);
    data_on <= 1'b0;
    tick(900);
    st(8'h07, 8'h07);
    wr(`ADDR_MISC_CTRL, {`CMD_SEARCH, 5'h00});
    st(8'h03, 8'h00);
    run <= 1'b0;
    wr(`ADDR_BAUD_TC, 8'h03);
    wr(`ADDR_IRQ_EN, 8'h02);
    wr(`ADDR_MISC_CTRL, 8'h01);
    tick(20);
    t0 = toggles;
    tick(100);
    chk(32'(toggles - t0), 32'h0);
    run <= 1'b1;
    tick(30);
    t0 = toggles;
    tick(400);
    chk(32'(toggles - t0 inside {[9:11]}), 32'h1);
    run <= 1'b0;
    wr(`ADDR_MISC_CTRL, 8'h03);
    tick(20);
    t0 = toggles;
    e0 = events;
    tick(200);
    chk(32'(toggles - t0 inside {[39:41]}), 32'h1);
    chk(32'(events - e0 inside {[39:41]}), 32'h1);
    wr(`ADDR_MISC_CTRL, 8'h02);
    tick(2);
    t0 = toggles;
    tick(50);
    chk(32'(toggles - t0), 32'h0);
    wr(`ADDR_IRQ_EN, 8'h00);
    break_status <= 1'b1;
    tick(5);
    e0 = events;
    wr(`ADDR_IRQ_EN, 8'h80);
    tick(5);
    chk(32'(events - e0), 32'h0);
    break_status <= 1'b0;
    tick(5);
    chk(32'(events - e0), 32'h1);
    wr(`ADDR_AUX_CTRL, 8'h01);
    tick(6);
    chk(32'(terminal_ready_req_n), 32'h0);
    wr(`ADDR_MISC_CTRL, 8'h04);
    tick(6);
    chk(32'(terminal_ready_req_n), 32'h1);
    tx_buffer_empty <= 1'b1;
    tick(8);
    chk(32'(terminal_ready_req_n), 32'h0);
    tx_buffer_empty <= 1'b0;
    tick(6);
    chk(32'(terminal_ready_req_n), 32'h1);
    wr(`ADDR_MISC_CTRL, 8'h10);
    repeat (8) begin
      @(posedge core_clk);
      tx_data <= ~tx_data;
    end
    tick(3);
    chk(32'(rx_data), 32'(tx_data));
    wr(`ADDR_MISC_CTRL, 8'h08);
    run <= 1'b1;
    data_on <= 1'b1;
    tick(300);
    chk(32'(txd_pin), 32'(rxd_pin));
    run <= 1'b0;
    wr(`ADDR_MISC_CTRL, {`CMD_SEARCH, 5'h1C});
    @(posedge core_clk);
    chan_reset <= 1'b1;
    @(posedge core_clk);
    chan_reset <= 1'b0;
    st(8'h38, 8'h00);
    e0 = events;
    lines <= 3'h3;
    tick(8);
    chk(32'(events - e0), 32'h1);
    wr(`ADDR_AUX_CTRL, 8'h10);
    wr(`ADDR_IRQ_EN, 8'h05);
    tick(2);
    chk(32'(status_fifo_active), 32'h1);
    chk(32'(prime_select), 32'h1);
    wr(`ADDR_AUX_CTRL, 8'h00);
    tick(2);
    chk(32'(status_fifo_active), 32'h0);
    wr(3'h5, 8'hFF);
    rd(3'h5, v);
    chk(v, 32'h0);
    rd(`ADDR_IRQ_EN, v);
    chk(v, 32'h0);
    end_of_test;
  end
endmodule // clock_recovery_loop_brg_misc_control_tb
